//--- hdl/embedded_power_ctrl.sv
/*
 * embedded power controller: request arbitration, power state machine and
 * table-driven sequencer that replays register writes onto resource bits.
 * assumes request and condition pins are asynchronous, the step table and
 * reference table are loaded as constant images, and the host write port
 * comes from serial control logic on mclk.
 */
// Functional notes
// - four request classes, five fixed sequences
// - untouched resources keep their preloaded defaults
// - resources set only through register bits
// - arbitration forwards one prioritised transition
// - state machine picks sequence from conditions
// - sequencer fetches and executes steps in order
// - sequencing timed at nominal 32768 Hz ticks
// - gpio enables controllable inside sequences
// - regulators switched by serial or request pins
// - dvs channel separate from configuration port
// - five states; sequences only off/active/sleep
// - only five transitions are permitted
// - off wins; on waits for off release
// - optional memory check on power-up, flag mismatch
`timescale 1ns/1ps
`include "power_seq_params.svh"

module embedded_power_ctrl (
    // clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // request and condition pins (asynchronous)
    input wire power_seq_pkg::req_s reqPins,
    input wire power_seq_pkg::sys_cond_s condPins,
    input wire logic hwPwrReq,
    // configuration strap
    input wire logic checkEnable,
    // host resource writes (general configuration port)
    input wire logic hostWrEn,
    input wire logic [3:0] hostWrIdx,
    input wire logic hostWrVal,
    // dedicated dvs channel
    input wire logic dvsWrEn,
    input wire logic [1:0] dvsConv,
    input wire logic dvsLevel,
    // state and resource outputs
    output power_seq_pkg::pwr_state_e pwrState,
    output logic [`RES_COUNT-1:0] resOn,
    output logic [`GPIO_EN_COUNT-1:0] gpioEn,
    output logic [2:0] dvsHigh,
    output logic seqBusy,
    output logic memCheckErr
);

    // ======================================================================
    // program memory images
    // ======================================================================
    // step table: eight-step slots per sequence, plain defaults
    logic [`STEP_W-1:0] stepRom [0:`STEP_DEPTH-1];
    logic [`STEP_W-1:0] refRom [0:`STEP_DEPTH-1]; // reference for the check

    // slots of 8 steps each; default image switches resource n, waits two ticks
    always_comb begin
        for (int i = 0; i < `STEP_DEPTH; i++) begin
            stepRom[i] = {((i % 8) == 3) ? 1'b1 : 1'b0, 4'(i % 16),
                          ((i / 8) == 1 || (i / 8) == 5) ? 1'b1 : 1'b0, 8'h01};
            refRom[i] = stepRom[i];
        end
    end

    // ======================================================================
    // input synchronisers
    // ======================================================================
    localparam int NSYNC = 9;
    logic [NSYNC-1:0] rawIn;
    logic [NSYNC-1:0] s1_reg, s2_reg, s3_reg, stab_reg;
    logic [NSYNC-1:0] s1_next, s2_next, s3_next, stab_next;

    assign rawIn = {reqPins, condPins, hwPwrReq};

    // three stages; a bit changes once stages two and three agree
    always_comb begin
        s1_next = rawIn;
        s2_next = s1_reg;
        s3_next = s2_reg;
        stab_next = stab_reg;
        for (int b = 0; b < NSYNC; b++) begin
            if (s2_reg[b] == s3_reg[b]) begin
                stab_next[b] = s3_reg[b];
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
            stab_reg <= '0;
        end else begin
            s1_reg <= s1_next;
            s2_reg <= s2_next;
            s3_reg <= s3_next;
            stab_reg <= stab_next;
        end
    end

    power_seq_pkg::req_s req;
    power_seq_pkg::sys_cond_s cond;
    logic hwReq;
    assign req = stab_reg[8:5];
    assign cond = stab_reg[4:1];
    assign hwReq = stab_reg[0];

    // ======================================================================
    // sequencing tick
    // ======================================================================
    logic tick;
    seq_tick_div u_tick (
        .mclk(mclk),
        .rstn(rstn),
        .tick(tick)
    );

    // ======================================================================
    // arbitration
    // ======================================================================
    power_seq_pkg::seq_sel_e grant; // single transition forwarded
    logic onGated;

    // on requests from off are gated by low supply or a hot die
    assign onGated = !cond.supplyHi || cond.hotDie;

    always_comb begin
        grant = power_seq_pkg::SeqNone;
        unique case (pwrState)
            power_seq_pkg::StActive: begin
                if (req.offReq) begin
                    grant = power_seq_pkg::SeqActiveToOff;
                end else if (req.sleepReq) begin
                    grant = power_seq_pkg::SeqActiveToSleep;
                end
            end
            power_seq_pkg::StSleep: begin
                if (req.offReq) begin
                    grant = power_seq_pkg::SeqSleepToOff;
                end else if (req.wakeReq || req.onReq) begin
                    grant = power_seq_pkg::SeqSleepToActive;
                end
            end
            power_seq_pkg::StOff: begin
                if (!req.offReq && req.onReq && !onGated) begin
                    grant = power_seq_pkg::SeqOffToActive;
                end
            end
            power_seq_pkg::StNoSupply, power_seq_pkg::StBackup: begin
                grant = power_seq_pkg::SeqNone;
            end
        endcase
    end

    // ======================================================================
    // power state machine and sequencer
    // ======================================================================
    typedef enum logic [1:0] {
        SqIdle,
        SqCheck,
        SqWrite,
        SqWait
    } sq_e;

    power_seq_pkg::pwr_state_e st_reg, st_next;
    power_seq_pkg::pwr_state_e tgt_reg, tgt_next; // state at sequence end
    sq_e sq_reg, sq_next;
    logic [`STEP_ADDR_W-1:0] pc_reg, pc_next;
    logic [`WAIT_W-1:0] wait_reg, wait_next;
    logic [`RES_COUNT-1:0] res_reg, res_next;
    logic [2:0] dvs_reg, dvs_next;
    logic err_reg, err_next;
    logic stop_reg, stop_next; // check mismatch blocks the step writes of that power-up
    power_seq_pkg::step_s step;

    assign step = stepRom[pc_reg];

    always_comb begin
        st_next = st_reg;
        tgt_next = tgt_reg;
        sq_next = sq_reg;
        pc_next = pc_reg;
        wait_next = wait_reg;
        res_next = res_reg;
        dvs_next = dvs_reg;
        err_next = err_reg;
        stop_next = stop_reg;
        // host and power request pins switch regulators
        // every path but the dvs write is a resource bit write
        if (hostWrEn) begin
            res_next[hostWrIdx] = hostWrVal;
        end
        if (hwReq && st_reg == power_seq_pkg::StActive) begin
            res_next[0] = 1'b1;
        end
        if (dvsWrEn && dvsConv != 2'h3) begin
            dvs_next[dvsConv] = dvsLevel;
        end
        if (!cond.supplyPor) begin
            st_next = power_seq_pkg::StNoSupply;
            sq_next = SqIdle;
            res_next = `RES_DEFAULT;
        end else if (!cond.supplyLo) begin
            st_next = power_seq_pkg::StBackup;
            sq_next = SqIdle;
            res_next = `RES_DEFAULT;
        end else begin
            unique case (sq_reg)
                SqIdle: begin
                    if (st_reg == power_seq_pkg::StNoSupply
                        || st_reg == power_seq_pkg::StBackup) begin
                        st_next = power_seq_pkg::StOff;
                    end else if (grant != power_seq_pkg::SeqNone) begin
                        // pick slot and target from grant
                        // one of five sequences
                        // slot k holds the sequence whose grant code is k
                        pc_next = {grant, 3'h0};
                        unique case (grant)
                            power_seq_pkg::SeqOffToActive,
                            power_seq_pkg::SeqSleepToActive:
                                tgt_next = power_seq_pkg::StActive;
                            power_seq_pkg::SeqActiveToSleep:
                                tgt_next = power_seq_pkg::StSleep;
                            default: tgt_next = power_seq_pkg::StOff;
                        endcase
                        stop_next = 1'b0;
                        if (grant == power_seq_pkg::SeqOffToActive && checkEnable) begin
                            sq_next = SqCheck;
                        end else begin
                            sq_next = SqWrite;
                        end
                    end
                end
                SqCheck: begin
                    for (int i = 0; i < `STEP_DEPTH; i++) begin
                        if (stepRom[i] != refRom[i]) begin
                            err_next = 1'b1;
                            stop_next = 1'b1;
                        end
                    end
                    sq_next = SqWrite;
                end
                SqWrite: begin
                    // step in order; gpio resources included
                    if (!stop_reg) begin
                        res_next[step.resIdx] = step.value;
                    end
                    wait_next = step.waitTicks;
                    sq_next = SqWait;
                end
                SqWait: begin
                    if (tick) begin
                        if (wait_reg != 8'h00) begin
                            wait_next = wait_reg - 8'h01;
                        end else if (step.last) begin
                            st_next = tgt_reg;
                            sq_next = SqIdle;
                        end else begin
                            pc_next = pc_reg + 6'h01;
                            sq_next = SqWrite;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            st_reg <= power_seq_pkg::StNoSupply;
            tgt_reg <= power_seq_pkg::StOff;
            sq_reg <= SqIdle;
            pc_reg <= 6'h00;
            wait_reg <= 8'h00;
            res_reg <= `RES_DEFAULT;
            dvs_reg <= 3'h0;
            err_reg <= 1'b0;
            stop_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            tgt_reg <= tgt_next;
            sq_reg <= sq_next;
            pc_reg <= pc_next;
            wait_reg <= wait_next;
            res_reg <= res_next;
            dvs_reg <= dvs_next;
            err_reg <= err_next;
            stop_reg <= stop_next;
        end
    end

    // ======================================================================
    // outputs
    // ======================================================================
    assign pwrState = st_reg;
    assign resOn = res_reg;
    // top resource bits are the external supply enables
    assign gpioEn = res_reg[`RES_COUNT-1 -: `GPIO_EN_COUNT];
    assign dvsHigh = dvs_reg;
    assign seqBusy = (sq_reg != SqIdle);
    assign memCheckErr = err_reg;

endmodule

//--- hdl/power_seq_params.svh
/*
 * timing counts and sequence table layout shared by the power controller files.
 * assumes mclk at 40 MHz; the sequencing tick is derived from it by a divider.
 */
`ifndef POWER_SEQ_PARAMS_SVH
`define POWER_SEQ_PARAMS_SVH

// ==========================================================================
// clocking
// ==========================================================================
`define MCLK_HZ 40000000
`define SEQ_TICK_HZ 32768
// whole mclk cycles per sequencing tick (rounded down, period slightly short)
`define SEQ_TICK_CYCLES (`MCLK_HZ / `SEQ_TICK_HZ)

// ==========================================================================
// resource and step layout
// ==========================================================================
`define RES_COUNT 16
`define GPIO_EN_COUNT 3
`define STEP_ADDR_W 6
`define STEP_DEPTH 64
`define WAIT_W 8
// one step word: {last, resource index[3:0], value, wait[7:0]}
`define STEP_W 14
`define STEP_LAST_BIT 13
`define STEP_RES_LSB 9
`define STEP_VAL_BIT 8
`define RES_DEFAULT 16'h0000

`endif

//--- hdl/power_seq_pkg.sv
/*
 * types for the embedded power controller.
 * assumes power_seq_params.svh is on the include path.
 */
`include "power_seq_params.svh"

package power_seq_pkg;

    // power states of the device
    typedef enum logic [2:0] {
        StNoSupply,
        StBackup,
        StOff,
        StActive,
        StSleep
    } pwr_state_e;

    // the five predefined transition sequences
    typedef enum logic [2:0] {
        SeqNone,
        SeqOffToActive,
        SeqActiveToOff,
        SeqSleepToOff,
        SeqActiveToSleep,
        SeqSleepToActive
    } seq_sel_e;

    // pending request classes
    typedef struct packed {
        logic onReq;
        logic offReq;
        logic wakeReq;
        logic sleepReq;
    } req_s;

    // system condition inputs
    typedef struct packed {
        logic supplyPor;
        logic supplyLo;
        logic supplyHi;
        logic hotDie;
    } sys_cond_s;

    // one step word from program memory
    typedef struct packed {
        logic last;
        logic [3:0] resIdx;
        logic value;
        logic [`WAIT_W-1:0] waitTicks;
    } step_s;

endpackage

//--- hdl/seq_tick_div.sv
/*
 * tick divider: one-cycle enable pulse at the nominal 32768 Hz sequencing rate.
 * assumes one mclk domain, synchronous active-low reset.
 */
`timescale 1ns/1ps
`include "power_seq_params.svh"

module seq_tick_div (
    // clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // tick output
    output logic tick
);

    // ======================================================================
    // divider counter
    // ======================================================================
    logic [10:0] cnt_reg; // cycles within one tick period
    logic [10:0] cnt_next;
    logic tick_reg;
    logic tick_next;

    // next count, wrap and pulse
    always_comb begin
        cnt_next = cnt_reg + 11'h001;
        tick_next = 1'b0;
        if (cnt_reg == 11'(`SEQ_TICK_CYCLES - 1)) begin
            cnt_next = 11'h000;
            tick_next = 1'b1;
        end
    end

    // register
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            cnt_reg <= 11'h000;
            tick_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            tick_reg <= tick_next;
        end
    end

    assign tick = tick_reg;

endmodule

//--- dv/embedded_power_ctrl_assertions.sv
/*
 * port checker for the embedded power controller.
 * assumes it is bound onto every embedded_power_ctrl instance, one mclk domain.
 */
`timescale 1ns/1ps
`include "power_seq_params.svh"

// ==========================================================================
// checker
// ==========================================================================
module embedded_power_ctrl_checker (
    // clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // requests and conditions
    input wire power_seq_pkg::req_s reqPins,
    input wire power_seq_pkg::sys_cond_s condPins,
    input wire logic hwPwrReq,
    // host and dvs writes
    input wire logic hostWrEn,
    input wire logic [3:0] hostWrIdx,
    input wire logic hostWrVal,
    input wire logic dvsWrEn,
    input wire logic [1:0] dvsConv,
    input wire logic dvsLevel,
    // state and resources
    input wire power_seq_pkg::pwr_state_e pwrState,
    input wire logic [`RES_COUNT-1:0] resOn,
    input wire logic [`GPIO_EN_COUNT-1:0] gpioEn,
    input wire logic [2:0] dvsHigh,
    input wire logic seqBusy,
    input wire logic memCheckErr
);
    // state decodes, kept plain so properties stay short
    logic isOff;
    logic isAct;
    logic isSlp;
    logic isLive;
    assign isOff = (pwrState == power_seq_pkg::StOff);
    assign isAct = (pwrState == power_seq_pkg::StActive);
    assign isSlp = (pwrState == power_seq_pkg::StSleep);
    assign isLive = isOff || isAct || isSlp;

    default clocking @(posedge mclk);
    endclocking
    default disable iff (!rstn);

    chk_reset_state: assert property ($rose(rstn) |-> isLive == 1'b0 && resOn == '0 && !seqBusy)
        else $error("state or resources not cleared by reset");
    chk_legal_move: assert property ($changed(pwrState) && $past(isLive) && isLive |->
        ($past(isOff) && isAct) || ($past(isAct) && !isAct) || ($past(isSlp) && !isSlp))
        else $error("illegal power state transition");
    chk_move_at_end: assert property ($changed(pwrState) && $past(isLive) && isLive |-> $fell(seqBusy))
        else $error("state moved outside the end of a sequence");
    chk_start_live: assert property ($rose(seqBusy) |-> isLive)
        else $error("sequence started outside off, active or sleep");
    chk_gpio_mirror: assert property (gpioEn == resOn[`RES_COUNT-1 -: `GPIO_EN_COUNT])
        else $error("gpio enables differ from their resource bits");
    chk_host_write: assert property (hostWrEn && !seqBusy |=> resOn[$past(hostWrIdx)] == $past(hostWrVal))
        else $error("host write did not land");
    // the power request pin reaches resource 0 five edges after it is sampled
    chk_res_quiet: assert property ($changed(resOn) |-> $past(hostWrEn) || $past(seqBusy)
        || $past(hwPwrReq, 5))
        else $error("resource changed without a write");
    chk_dvs_write: assert property (dvsWrEn && dvsConv != 2'h3 |=> dvsHigh[$past(dvsConv)] == $past(dvsLevel))
        else $error("dvs write did not land");
    chk_dvs_ignore: assert property (dvsWrEn && dvsConv == 2'h3 |=> $stable(dvsHigh))
        else $error("dvs write to unused converter took effect");
    chk_on_gated: assert property ((isOff && !seqBusy && (condPins.hotDie || reqPins.offReq
        || !condPins.supplyHi))[*6] |=> !seqBusy)
        else $error("power up started while gated");
    chk_err_sticky: assert property (memCheckErr |=> memCheckErr)
        else $error("memory check flag dropped");
endmodule

bind embedded_power_ctrl embedded_power_ctrl_checker chk (.mclk(mclk), .rstn(rstn),
    .reqPins(reqPins), .condPins(condPins), .hwPwrReq(hwPwrReq), .hostWrEn(hostWrEn),
    .hostWrIdx(hostWrIdx),
    .hostWrVal(hostWrVal), .dvsWrEn(dvsWrEn), .dvsConv(dvsConv), .dvsLevel(dvsLevel),
    .pwrState(pwrState), .resOn(resOn), .gpioEn(gpioEn), .dvsHigh(dvsHigh),
    .seqBusy(seqBusy), .memCheckErr(memCheckErr));

//--- dv/host_model.sv
/*
 * host processor model: resource writes and dvs commands on two channels.
 * assumes writes launch at the falling edge and last one mclk cycle.
 */
`timescale 1ns/1ps

// ==========================================================================
// host model
// ==========================================================================
module host_model (
    // clock
    input wire logic mclk,
    // general resource port
    output logic hostWrEn,
    output logic [3:0] hostWrIdx,
    output logic hostWrVal,
    // dedicated dvs channel
    output logic dvsWrEn,
    output logic [1:0] dvsConv,
    output logic dvsLevel
);
    // idle ports at time zero
    initial begin
        hostWrEn = 1'b0;
        hostWrIdx = 4'h0;
        hostWrVal = 1'b0;
        dvsWrEn = 1'b0;
        dvsConv = 2'h0;
        dvsLevel = 1'b0;
    end

    // host resource write
    // released lines flip so a stale value never passes for a write
    task automatic write_res(input logic [3:0] idx, input logic val);
        @(negedge mclk);
        hostWrEn = 1'b1;
        hostWrIdx = idx;
        hostWrVal = val;
        @(negedge mclk);
        hostWrEn = 1'b0;
        hostWrIdx = ~idx;
        hostWrVal = ~val;
    endtask

    task automatic write_dvs(input logic [1:0] conv, input logic level);
        @(negedge mclk);
        dvsWrEn = 1'b1;
        dvsConv = conv;
        dvsLevel = level;
        @(negedge mclk);
        dvsWrEn = 1'b0;
        dvsConv = ~conv;
        dvsLevel = ~level;
    endtask
endmodule

//--- dv/tb_embedded_power_ctrl.sv
/*
 * testbench for the embedded power controller: host writes, all five sequences,
 * gating and priority, mid-run reset.
 * assumes the default step image and a 1220-cycle sequencing tick.
 */
`timescale 1ns/1ps
`include "power_seq_params.svh"

// ==========================================================================
// bench top
// ==========================================================================
module tb_embedded_power_ctrl;
    // one row: a write and the outputs it should leave
    typedef struct packed {
        logic isDvs;
        logic [3:0] idx;
        logic val;
        logic [15:0] expRes;
        logic [2:0] expDvs;
    } row_s;
    localparam int TICK = `SEQ_TICK_CYCLES;
    localparam logic [15:0] stNoS = 16'(power_seq_pkg::StNoSupply);
    localparam logic [15:0] stOff = 16'(power_seq_pkg::StOff);
    localparam logic [15:0] stAct = 16'(power_seq_pkg::StActive);
    localparam logic [15:0] stSlp = 16'(power_seq_pkg::StSleep);
    logic mclk;
    logic rstn;
    power_seq_pkg::req_s reqPins;
    power_seq_pkg::sys_cond_s condPins;
    logic hostWrEn;
    logic [3:0] hostWrIdx;
    logic hostWrVal;
    logic dvsWrEn;
    logic [1:0] dvsConv;
    logic dvsLevel;
    logic hwPwrReq; // power request pin, raised only while active and idle
    power_seq_pkg::pwr_state_e pwrState;
    logic [15:0] resOn;
    logic [2:0] gpioEn;
    logic [2:0] dvsHigh;
    logic seqBusy;
    logic memCheckErr;
    int failures;
    int comparisons;
    row_s rows [9];

    // the power request pin stays low during all host writes
    embedded_power_ctrl uut (.mclk(mclk), .rstn(rstn), .reqPins(reqPins),
        .condPins(condPins), .hwPwrReq(hwPwrReq), .checkEnable(1'b1), .hostWrEn(hostWrEn),
        .hostWrIdx(hostWrIdx), .hostWrVal(hostWrVal), .dvsWrEn(dvsWrEn),
        .dvsConv(dvsConv), .dvsLevel(dvsLevel), .pwrState(pwrState), .resOn(resOn),
        .gpioEn(gpioEn), .dvsHigh(dvsHigh), .seqBusy(seqBusy), .memCheckErr(memCheckErr));
    host_model host (.mclk(mclk), .hostWrEn(hostWrEn), .hostWrIdx(hostWrIdx),
        .hostWrVal(hostWrVal), .dvsWrEn(dvsWrEn), .dvsConv(dvsConv), .dvsLevel(dvsLevel));

    // 40 MHz clock
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    // compare and count
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // verdict and end of run
    task automatic report_and_stop();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // raise a request, drop it once granted, optionally poke off mid-sequence
    task automatic run_seq(input string name, input power_seq_pkg::req_s r,
            input logic [15:0] expState, input logic [15:0] expRes, input bit pokeOff);
        int n;
        n = 0;
        @(negedge mclk);
        reqPins = r;
        while (seqBusy !== 1'b1 && n < 50) begin
            @(negedge mclk);
            n++;
        end
        check({name, " start"}, 16'h1, {15'h0, seqBusy});
        reqPins = '0;
        n = 0;
        while (seqBusy === 1'b1 && n < 12000) begin
            @(negedge mclk);
            n++;
            if (pokeOff) reqPins.offReq = (n >= 100 && n < 120);
        end
        // four steps of two ticks each, first one may start mid-tick
        check({name, " length"}, 16'h1, {15'h0, n >= 6 * TICK && n <= 8 * TICK + 64});
        check({name, " state"}, expState, 16'(pwrState));
        check({name, " res"}, expRes, resOn);
        $display("test %s done", name);
    endtask

    // watchdog: seven sequences of under 10000 cycles each
    initial begin
        repeat (90000) @(posedge mclk);
        failures++;
        report_and_stop();
    end

    // main sequence
    initial begin
        rstn = 1'b0;
        reqPins = '0;
        hwPwrReq = 1'b0;
        condPins = 4'hE;
        failures = 0;
        comparisons = 0;
        rows = '{'{1'b0, 4'hD, 1'b1, 16'h2000, 3'h0}, '{1'b0, 4'hF, 1'b1, 16'hA000, 3'h0},
            '{1'b0, 4'hE, 1'b1, 16'hE000, 3'h0}, '{1'b0, 4'hD, 1'b0, 16'hC000, 3'h0},
            '{1'b1, 4'h0, 1'b1, 16'hC000, 3'h1}, '{1'b1, 4'h2, 1'b1, 16'hC000, 3'h5},
            '{1'b1, 4'h3, 1'b1, 16'hC000, 3'h5}, '{1'b1, 4'h0, 1'b0, 16'hC000, 3'h4},
            '{1'b0, 4'h1, 1'b1, 16'hC002, 3'h4}};
        repeat (5) @(negedge mclk);
        rstn = 1'b1;
        repeat (20) @(negedge mclk);
        check("off reached", stOff, 16'(pwrState));
        foreach (rows[i]) begin
            if (rows[i].isDvs) host.write_dvs(rows[i].idx[1:0], rows[i].val);
            else host.write_res(rows[i].idx, rows[i].val);
            @(negedge mclk);
            check("row res", rows[i].expRes, resOn);
            check("row gpio", {13'h0, rows[i].expRes[15:13]}, {13'h0, gpioEn});
            check("row dvs", {13'h0, rows[i].expDvs}, {13'h0, dvsHigh});
        end
        $display("test host writes done");
        // hot die and a pending off both hold back power up
        condPins.hotDie = 1'b1;
        repeat (10) @(negedge mclk);
        reqPins.onReq = 1'b1;
        repeat (40) @(negedge mclk);
        check("hot gate", 16'h0, {15'h0, seqBusy});
        reqPins.offReq = 1'b1;
        condPins.hotDie = 1'b0;
        repeat (40) @(negedge mclk);
        check("off holds", 16'h0, {15'h0, seqBusy});
        $display("test gating done");
        run_seq("power up", 4'h8, stAct, 16'hCF02, 1'b0);
        check("mem check", 16'h0, {15'h0, memCheckErr});
        run_seq("to sleep", 4'h1, stSlp, 16'hCF00, 1'b1);
        run_seq("wake", 4'h2, stAct, 16'hCF00, 1'b0);
        run_seq("off wins", 4'h5, stOff, 16'hCF00, 1'b0);
        run_seq("power again", 4'h8, stAct, 16'hCF00, 1'b0);
        // power request pin forces resource 0 on while active; the bit then stands
        hwPwrReq = 1'b1;
        repeat (10) @(negedge mclk);
        hwPwrReq = 1'b0;
        check("hw request", 16'hCF01, resOn);
        $display("test hw request done");
        run_seq("sleep again", 4'h1, stSlp, 16'hCF00, 1'b0);
        run_seq("sleep off", 4'h4, stOff, 16'hC000, 1'b0);
        // reset in mid-run
        rstn = 1'b0;
        repeat (5) @(negedge mclk);
        check("reset state", stNoS, 16'(pwrState));
        check("reset res", 16'h0, resOn);
        check("reset busy", 16'h0, {15'h0, seqBusy});
        check("reset err", 16'h0, {15'h0, memCheckErr});
        rstn = 1'b1;
        @(negedge mclk);
        check("release state", stNoS, 16'(pwrState));
        check("release busy", 16'h0, {15'h0, seqBusy});
        repeat (20) @(negedge mclk);
        check("off again", stOff, 16'(pwrState));
        check("release res", 16'h0, resOn);
        $display("test reset done");
        report_and_stop();
    end
endmodule
